/* File: logic/iodt_defs.vh */
// Purpose: Constants for the transfer command sequencer
// Assumes: Included by bare name
// Notes: Action codes are three bits
`ifndef IODT_DEFS_VH
`define IODT_DEFS_VH
`define IODT_ACT_DISC 3'h0
`define IODT_ACT_IN 3'h1
`define IODT_ACT_OUT 3'h2
`define IODT_ACT_INOUT 3'h3
`define IODT_ACT_EOM 3'h4
`define IODT_ACT_EOM_IN 3'h5
`define IODT_ACT_EOM_OUT 3'h6
`define IODT_ACT_STAT 3'h7
`define IODT_ST_IDLE 2'h0
`define IODT_ST_WAIT 2'h1
`define IODT_ST_DONE 2'h2
`define IODT_BUS_W 24
`define IODT_DATA_RST 24'h00_0000
`endif

/* File: logic/iodt_decode.v */
// Purpose: Action field decode into strobes
// Assumes: Purely combinational
// Notes: One strobe output per function; codes 3, 5 and 6 raise two at once
`timescale 1ns/10ps
`include "iodt_defs.vh"
module iodt_decode (
  input wire [2:0] i_action_field,
  output reg o_in,
  output reg o_out,
  output reg o_eom,
  output reg o_disc,
  output reg o_stat
);
  always @* begin
    o_in = 1'b0;
    o_out = 1'b0;
    o_eom = 1'b0;
    o_disc = 1'b0;
    o_stat = 1'b0;
    case (i_action_field)
      // (RULE3) Disconnect code
      `IODT_ACT_DISC: begin
        o_disc = 1'b1;
      end
      // (RULE1) Direction codes
      `IODT_ACT_IN: begin
        o_in = 1'b1;
      end
      `IODT_ACT_OUT: begin
        o_out = 1'b1;
      end
      `IODT_ACT_INOUT: begin
        o_in = 1'b1;
        o_out = 1'b1;
      end
      // (RULE2) End of message codes
      `IODT_ACT_EOM: begin
        o_eom = 1'b1;
      end
      `IODT_ACT_EOM_IN: begin
        o_in = 1'b1;
        o_eom = 1'b1;
      end
      `IODT_ACT_EOM_OUT: begin
        o_out = 1'b1;
        o_eom = 1'b1;
      end
      // (RULE3) Status request code
      `IODT_ACT_STAT: begin
        o_stat = 1'b1;
      end
      default: begin
        o_disc = 1'b0;
      end
    endcase
  end
endmodule // iodt_decode

/* File: logic/iodt_transfer.v */
// Purpose: Computer-side transfer command sequencer
// Assumes: Controller signals arrive asynchronously
// Notes: One command at a time
// Functional notes
// (RULE1) Codes 001, 010, 011 raise in, out, or both strobes.
// (RULE2) Codes 100, 101, 110 raise end-of-message, with in or out.
// (RULE3) Code 000 raises disconnect; 111 raises status request.
// (RULE4) Completion skips, except disconnect or special condition gives non-skip.
// (RULE5) Controller raises special condition only in its command, before echo.
// (RULE6) Controller puts status word on input bus on status request.
// (RULE7) Disconnect clears controller online latch, freeing its channel.
// (RULE8) Computer ends disconnect itself, without waiting for echo.
// (RULE9) Disconnected controller sends no interrupts nor data.
// (RULE10) Block controllers complete the block on end-of-message.
// (RULE11) Channel enable, one of four, only while commutator is locked.
// (RULE12) Commutator locks on serviced interrupt or by program command.
// (RULE13) Controller holds channel interrupt while data ready or unprocessed.
// (RULE14) Enable, strobes and output data driven immediately on command.
// (RULE15) Controller matches channel enable against its assignment.
// (RULE16) Transfer request needs match, online latch and readiness.
// (RULE17) Controller sync flip-flop set after match and request.
// (RULE18) Computer waits until controller is ready and echoes.
// (RULE19) Input handshake states 00 ready through 11 sending.
// (RULE20) Output handshake states 00 ready through 11 outputting.
// (RULE21) Controller echoes at completion, drops it when command ends.
// (RULE22) Controller transfers only after selection set its online latch.
// (RULE23) Channel assignment comes from two selection word bits.
`timescale 1ns/10ps
`include "iodt_defs.vh"
module iodt_transfer (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_start,
  input wire [2:0] i_action_field,
  input wire [23:0] i_out_data,
  input wire i_auto_lock,
  input wire i_prog_lock,
  input wire [1:0] i_prog_channel,
  input wire [3:0] i_channel_interrupt,
  input wire i_terminating_echo,
  input wire i_special_condition,
  input wire [23:0] i_in_bus,
  output wire [3:0] o_channel_enable,
  output reg o_transfer_in_strobe,
  output reg o_transfer_out_strobe,
  output reg o_end_of_message,
  output reg o_disconnect_strobe,
  output reg o_status_request,
  output reg [23:0] o_out_bus,
  output wire o_busy,
  output reg o_done,
  output reg o_skip,
  output reg [23:0] o_in_data,
  output reg o_commutator_locked,
  output reg [1:0] o_locked_channel
);
  reg [3:0] irq_s1;
  reg [3:0] irq_s2;
  reg eko_s1;
  reg eko_s2;
  reg spl_s1;
  reg spl_s2;
  reg [23:0] rbus_s1;
  reg [23:0] rbus_s2;
  reg [1:0] state;
  reg [1:0] next_state;
  reg spl_seen;
  wire dec_in;
  wire dec_out;
  wire dec_eom;
  wire dec_disc;
  wire dec_stat;

  // Lowest interrupting channel wins
  function [1:0] iodt_prio;
    input [3:0] req;
    begin
      if (req[0]) begin
        iodt_prio = 2'h0;
      end else if (req[1]) begin
        iodt_prio = 2'h1;
      end else if (req[2]) begin
        iodt_prio = 2'h2;
      end else begin
        iodt_prio = 2'h3;
      end
    end
  endfunction

  iodt_decode u_dec (
    .i_action_field(i_action_field),
    .o_in(dec_in),
    .o_out(dec_out),
    .o_eom(dec_eom),
    .o_disc(dec_disc),
    .o_stat(dec_stat)
  );

  // Synchronise controller inputs
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_s1 <= 4'h0;
      irq_s2 <= 4'h0;
      eko_s1 <= 1'b0;
      eko_s2 <= 1'b0;
      spl_s1 <= 1'b0;
      spl_s2 <= 1'b0;
      rbus_s1 <= `IODT_DATA_RST;
      rbus_s2 <= `IODT_DATA_RST;
    end else if (i_ce) begin
      irq_s1 <= i_channel_interrupt;
      irq_s2 <= irq_s1;
      eko_s1 <= i_terminating_echo;
      eko_s2 <= eko_s1;
      spl_s1 <= i_special_condition;
      spl_s2 <= spl_s1;
      rbus_s1 <= i_in_bus;
      rbus_s2 <= rbus_s1;
    end
  end

  // (RULE12) Commutator lock
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_commutator_locked <= 1'b0;
      o_locked_channel <= 2'h0;
    end else if (i_ce && state == `IODT_ST_IDLE) begin
      if (i_prog_lock) begin
        o_commutator_locked <= 1'b1;
        o_locked_channel <= i_prog_channel;
      end else if (i_auto_lock && irq_s2 != 4'h0) begin
        o_commutator_locked <= 1'b1;
        o_locked_channel <= iodt_prio(irq_s2);
      end
    end
  end

  // (RULE11) Enable only when locked
  assign o_channel_enable = (state == `IODT_ST_WAIT && o_commutator_locked) ?
    (4'h1 << o_locked_channel) : 4'h0;

  // Busy from start until idle
  assign o_busy = (state != `IODT_ST_IDLE);

  always @* begin
    next_state = state;
    case (state)
      `IODT_ST_IDLE: begin
        if (i_start) begin
          next_state = `IODT_ST_WAIT;
        end
      end
      // (RULE8) Disconnect ends internally
      // (RULE18) Wait for echo
      `IODT_ST_WAIT: begin
        if (o_disconnect_strobe || eko_s2) begin
          next_state = `IODT_ST_DONE;
        end
      end
      `IODT_ST_DONE: begin
        if (!eko_s2) begin
          next_state = `IODT_ST_IDLE;
        end
      end
      default: begin
        next_state = `IODT_ST_IDLE;
      end
    endcase
  end

  // State register and strobes
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= `IODT_ST_IDLE;
      o_transfer_in_strobe <= 1'b0;
      o_transfer_out_strobe <= 1'b0;
      o_end_of_message <= 1'b0;
      o_disconnect_strobe <= 1'b0;
      o_status_request <= 1'b0;
      o_out_bus <= `IODT_DATA_RST;
      o_in_data <= `IODT_DATA_RST;
      o_done <= 1'b0;
      o_skip <= 1'b0;
      spl_seen <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      o_done <= 1'b0;
      if (state == `IODT_ST_IDLE && i_start) begin
        // (RULE14) Strobes and data at once
        o_transfer_in_strobe <= dec_in;
        o_transfer_out_strobe <= dec_out;
        o_end_of_message <= dec_eom;
        o_disconnect_strobe <= dec_disc;
        o_status_request <= dec_stat;
        o_out_bus <= dec_out ? i_out_data : `IODT_DATA_RST;
        spl_seen <= 1'b0;
      end else if (state == `IODT_ST_WAIT) begin
        // Latch special condition
        if (spl_s2) begin
          spl_seen <= 1'b1;
        end

        // Capture result, clear strobes
        if (next_state == `IODT_ST_DONE) begin
          if (o_transfer_in_strobe || o_status_request) begin
            o_in_data <= rbus_s2;
          end
          // (RULE4) Skip or non-skip
          o_skip <= !(o_disconnect_strobe || spl_seen || spl_s2);
          o_done <= 1'b1;
          o_transfer_in_strobe <= 1'b0;
          o_transfer_out_strobe <= 1'b0;
          o_end_of_message <= 1'b0;
          o_disconnect_strobe <= 1'b0;
          o_status_request <= 1'b0;
          o_out_bus <= `IODT_DATA_RST;
        end
      end
    end
  end
endmodule // iodt_transfer

/* File: bench/iodt_transfer_assertions.sv */
// Purpose: port checks of the sequencer
// Assumes: one clock
// Notes: bound to the top
`timescale 1ns/10ps
module iodt_checker (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire [2:0] i_action_field,
  input wire [3:0] o_channel_enable,
  input wire o_transfer_in_strobe,
  input wire o_transfer_out_strobe,
  input wire o_end_of_message,
  input wire o_disconnect_strobe,
  input wire o_status_request,
  input wire o_done,
  input wire o_skip
);
  wire [2:0] a = i_action_field;
  wire d = o_transfer_in_strobe | o_transfer_out_strobe;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  in_strobe_a: assert property (o_transfer_in_strobe |-> a[0] && a != 3'h7)
    else $error("in strobe");
  out_strobe_a: assert property (o_transfer_out_strobe |-> a[1] && a != 3'h7)
    else $error("out strobe");
  eom_strobe_a: assert property (o_end_of_message |-> a[2] && a != 3'h7)
    else $error("eom strobe");
  disc_only_a: assert property (o_disconnect_strobe |-> a == 3'h0 && !d)
    else $error("disconnect");
  stat_only_a: assert property (o_status_request |-> a == 3'h7 && !d)
    else $error("status");
  one_enable_a: assert property ($onehot0(o_channel_enable))
    else $error("enable");
  strobe_en_a: assert property (d |-> |o_channel_enable)
    else $error("no enable");
  disc_skip_a: assert property (o_done && a == 3'h0 |-> !o_skip)
    else $error("skip");
  cover property (o_done && o_skip);
  cover property (o_done && !o_skip);
  cover property (o_status_request);
endmodule // iodt_checker
bind iodt_transfer iodt_checker i_chk (.*);

/* File: bench/iodt_ctrl_model.sv */
// Purpose: peripheral controller model
// Assumes: selected once
// Notes: released bus toggles
`timescale 1ns/10ps
module iodt_ctrl_model #(
  parameter [23:0] STAT = 24'h00_c3c3
) (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_select,
  input wire [1:0] i_assign,
  input wire i_ready,
  input wire i_spl,
  input wire [23:0] i_data,
  input wire [3:0] i_channel_enable,
  input wire i_act,
  input wire i_stat,
  input wire i_disc,
  input wire i_eom,
  output wire o_echo,
  output wire o_spl,
  output wire [23:0] o_bus,
  output wire [3:0] o_irq,
  output reg [3:0] o_blocks
);
  reg online;
  reg sync;
  reg handshake_latch;
  reg handshake_reset;
  reg [23:0] last;
  wire match = i_channel_enable[i_assign];
  wire req = match & online & handshake_latch & i_act;
  assign o_echo = sync & req;
  assign o_spl = req & i_spl;
  assign o_bus = req ? (i_stat ? STAT : i_data) : ~last;
  assign o_irq = online ? 4'h1 << i_assign : 4'h0;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      online <= 1'b0;
      sync <= 1'b0;
      last <= 24'h00_0000;
      handshake_latch <= 1'b0;
      handshake_reset <= 1'b0;
      o_blocks <= 4'h0;
    end else begin
      last <= o_bus;
      sync <= req;
      if (i_select)
        online <= 1'b1;
      else if (match & i_disc)
        online <= 1'b0;
      // buffer states: 10 loaded, 11 sending, 01 clearable, 00 ready
      if (req) begin
        handshake_latch <= 1'b1;
        handshake_reset <= 1'b1;
      end else if (handshake_latch & handshake_reset) begin
        handshake_latch <= 1'b0;
      end else if (handshake_reset) begin
        handshake_reset <= 1'b0;
      end else if (i_ready & online) begin
        handshake_latch <= 1'b1;
      end
      // end of message closes a block
      if (req & !sync & i_eom)
        o_blocks <= o_blocks + 4'h1;
    end
  end
endmodule // iodt_ctrl_model

/* File: bench/iodt_transfer_bench.sv */
// Purpose: bench of the sequencer
// Assumes: controller model
// Notes: random data
`timescale 1ns/10ps
module iodt_transfer_bench;
  localparam [23:0] STAT = 24'h00_c3c3;
  reg i_ref_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg i_ce = 1'b1;
  reg i_start = 1'b0;
  reg i_auto_lock = 1'b0;
  reg i_prog_lock = 1'b0;
  reg [1:0] i_prog_channel = 2'h0;
  reg [2:0] i_action_field = 3'h0;
  reg [23:0] i_out_data = 24'h00_0000;
  reg [23:0] dat = 24'h00_0000;
  reg sel = 1'b0;
  reg rdy = 1'b0;
  reg special_condition = 1'b0;
  wire [3:0] i_channel_interrupt, o_channel_enable;
  wire [23:0] i_in_bus, o_out_bus, o_in_data;
  wire [1:0] o_locked_channel;
  wire i_terminating_echo, i_special_condition, o_transfer_in_strobe, o_transfer_out_strobe;
  wire o_end_of_message, o_disconnect_strobe, o_status_request, o_busy, o_done, o_skip;
  wire o_commutator_locked;
  wire [3:0] blocks;
  integer seed = 58;
  integer failures = 0;
  integer n_compared = 0;
  integer c;
  reg [25:0] e;
  reg [25:0] exp_q [$];
  iodt_transfer i_dut (.*);
  iodt_ctrl_model #(.STAT(STAT)) i_model (.i_ref_clk, .i_rstn, .i_select(sel),
    .i_assign(i_prog_channel), .i_ready(rdy), .i_spl(special_condition), .i_data(dat),
    .i_channel_enable(o_channel_enable), .i_stat(o_status_request),
    .i_act(o_transfer_in_strobe | o_transfer_out_strobe | o_end_of_message | o_status_request),
    .i_disc(o_disconnect_strobe), .o_echo(i_terminating_echo), .o_spl(i_special_condition),
    .i_eom(o_end_of_message), .o_bus(i_in_bus), .o_irq(i_channel_interrupt),
    .o_blocks(blocks));
  initial forever #25 i_ref_clk = ~i_ref_clk;
  task check(input string nm, input [23:0] seen, input [23:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task test_done;
    begin
      $display("failures %0d n_compared %0d", failures, n_compared);
      if (failures == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task cmd(input [2:0] code, input s);
    integer k;
    integer r;
    reg [23:0] d;
    reg [23:0] q;
    begin
      d = 24'($random(seed));
      q = 24'($random(seed));
      r = $random(seed) & 3;
      @(posedge i_ref_clk);
      i_prog_lock <= 1'b1;
      @(posedge i_ref_clk);
      i_prog_lock <= 1'b0;
      i_action_field <= code;
      dat <= d;
      i_out_data <= q;
      special_condition <= s;
      i_start <= 1'b1;
      exp_q.push_back({code[0], code != 3'h0 && !s, code == 3'h7 ? STAT : d});
      @(posedge i_ref_clk);
      i_start <= 1'b0;
      for (k = 0; k < 64 && o_done !== 1'b1; k = k + 1) begin
        if (k == r)
          rdy <= 1'b1;
        @(negedge i_ref_clk);
        if (k == 0) begin
          check("out bus", o_out_bus, code[1] && code != 3'h7 ? q : 24'h00_0000);
          check("enable", o_channel_enable, 4'h1 << i_prog_channel);
          check("lock", {o_commutator_locked, o_locked_channel}, {1'b1, i_prog_channel});
          check("busy", o_busy, 1'b1);
        end
        if (o_done !== 1'b1)
          @(posedge i_ref_clk);
      end
      if (o_done !== 1'b1) begin
        failures = failures + 1;
        test_done;
      end
      @(posedge i_ref_clk);
      rdy <= 1'b0;
    end
  endtask
  always @(negedge i_ref_clk)
    if (o_done === 1'b1) begin
      check("pending", 24'(exp_q.size() > 0), 24'h00_0001);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check("skip", o_skip, e[24]);
        if (e[25])
          check("in data", o_in_data, e[23:0]);
      end
    end
  initial begin
    i_prog_channel <= 2'($random(seed));
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    @(posedge i_ref_clk);
    sel <= 1'b1;
    @(posedge i_ref_clk);
    sel <= 1'b0;
    @(posedge i_ref_clk);
    check("irq", i_channel_interrupt, 4'h1 << i_prog_channel);
    check("idle", {o_busy, o_commutator_locked}, 2'h0);
    i_auto_lock <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_auto_lock <= 1'b0;
    @(negedge i_ref_clk);
    check("auto lock", {o_commutator_locked, o_locked_channel}, {1'b1, i_prog_channel});
    for (c = 1; c < 8; c = c + 1)
      cmd(c[2:0], 1'b0);
    cmd(3'h5, 1'b1);
    cmd(3'h0, 1'b0);
    @(posedge i_ref_clk);
    check("irq off", i_channel_interrupt, 4'h0);
    check("blocks", blocks, 4'h4);
    check("queue", 24'(exp_q.size()), 24'h00_0000);
    test_done;
  end
endmodule // iodt_transfer_bench
